// *** hw/adc_result_format_regs.sv ***
// The address map and the address-and-strobe port are this design's own decisions.
`include "adc_fmt_regs.svh"

// Register side of a ten-bit converter with result justification.
module adc_result_format_regs (
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RST_N,
    // Register port.
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Converter core.
    input wire logic [9:0] CONV_SAMPLE,
    output logic [2:0] CHANNEL,
    output logic VREF_SELECT,
    output logic CONV_POWER,
    output logic SAMPLE_HOLD,
    output logic [7:0] PIN_ANALOG,
    // Interrupt.
    output logic IRQ
);

    logic [7:0] control; // Format, reference, channel, go, enable.
    logic [7:0] clock_sel; // Conversion clock select.
    logic [7:0] pin_sel; // Analog pin select.
    logic [7:0] irq_enable; // Interrupt mask.
    logic irq_flag; // Sticky converter event flag.
    logic [7:0] result_high; // Result high byte, not reset.
    logic [7:0] result_low; // Result low byte, not reset.
    logic [7:0] next_control;
    logic [7:0] next_clock_sel;
    logic [7:0] next_pin_sel;
    logic [7:0] next_irq_enable;
    logic next_irq_flag;
    logic [7:0] next_result_high;
    logic [7:0] next_result_low;
    adc_fmt_pkg::conv_state_t state; // Sequencer state.
    adc_fmt_pkg::conv_state_t next_state;
    logic [3:0] tad_count; // Conversion periods done.
    logic [3:0] next_tad_count;
    logic end_of_conv; // High in the cycle a conversion finishes.
    logic tad_tick; // Conversion clock enable pulse.
    logic [9:0] sample_meta; // First synchroniser stage.
    logic [9:0] sample_sync; // Second synchroniser stage.
    logic [7:0] pack_high; // Formatted high byte.
    logic [7:0] pack_low; // Formatted low byte.
    logic [7:0] next_rdata;
    logic next_irq;
    logic next_hold;
    logic go_bit; // Conversion in progress flag.
    logic enable_bit; // Converter powered.
    logic format_bit; // Right justification chosen.

    assign go_bit = control[`CTL_GO_BIT];
    assign enable_bit = control[`CTL_ENABLE_BIT];
    assign format_bit = control[`CTL_FORMAT_BIT];

    // Makes the conversion clock from the selected divide ratio.
    tad_divider divider (
        .clock(CLOCK),
        .rst_n(RST_N),
        .run(state == adc_fmt_pkg::CONV_RUN),
        .select(clock_sel[`CLKSEL_MSB:`CLKSEL_LSB]),
        .tick(tad_tick)
    );

    // Lays the synchronised sample out in the chosen format.
    result_packer packer (
        .value(sample_sync),
        .right_justify(format_bit),
        .high_byte(pack_high),
        .low_byte(pack_low)
    );

    // Brings the sample from the converter core into this domain.
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            sample_meta <= `SAMPLE_RESET;
            sample_sync <= `SAMPLE_RESET;
        end
        else
        begin
            sample_meta <= CONV_SAMPLE;
            sample_sync <= sample_meta;
        end
    end

    // Sequences a conversion of a fixed number of conversion periods.
    // Starting is left to software once the input has settled.
    always_comb
    begin
        next_state = state;
        next_tad_count = tad_count;
        end_of_conv = 1'b0;
        case (state)
            adc_fmt_pkg::CONV_IDLE:
            begin
                next_tad_count = `TAD_ZERO;
                // RULE6 start on go
                if (go_bit && enable_bit)
                    next_state = adc_fmt_pkg::CONV_RUN;
            end
            adc_fmt_pkg::CONV_RUN:
            begin
                // A cleared go or enable bit abandons the conversion.
                if (!go_bit || !enable_bit)
                    next_state = adc_fmt_pkg::CONV_IDLE;
                else if (tad_tick)
                begin
                    next_tad_count = tad_count + `TAD_ONE;
                    if (tad_count == `CONV_TAD_COUNT - `TAD_ONE)
                    begin
                        end_of_conv = 1'b1;
                        next_state = adc_fmt_pkg::CONV_IDLE;
                    end
                end
            end
            default: next_state = adc_fmt_pkg::CONV_IDLE;
        endcase
        next_hold = (next_state == adc_fmt_pkg::CONV_RUN);
    end

    // Registers the sequencer.
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            state <= adc_fmt_pkg::CONV_IDLE;
            tad_count <= `TAD_ZERO;
            SAMPLE_HOLD <= 1'b0;
        end
        else
        begin
            state <= next_state;
            tad_count <= next_tad_count;
            SAMPLE_HOLD <= next_hold;
        end
    end

    // Computes the software-written configuration and the event flag.
    always_comb
    begin
        next_control = control;
        next_clock_sel = clock_sel;
        next_pin_sel = pin_sel;
        next_irq_enable = irq_enable;
        next_irq_flag = irq_flag;
        if (WR && ADDR == `OFS_CONTROL)
            next_control = WDATA & `CTL_WRITE_MASK;
        else if (WR && ADDR == `OFS_CLOCK_SEL)
            next_clock_sel = WDATA & `CLKSEL_WRITE_MASK;
        else if (WR && ADDR == `OFS_PIN_SEL)
            next_pin_sel = WDATA;
        else if (WR && ADDR == `OFS_IRQ_ENABLE)
            next_irq_enable = WDATA;
        else if (WR && ADDR == `OFS_IRQ_FLAGS)
            next_irq_flag = WDATA[`IRQ_CONV_BIT];
        // Reading the flag register clears it.
        if (RD && ADDR == `OFS_IRQ_FLAGS)
            next_irq_flag = 1'b0;
        // Powering down also drops a pending go.
        if (!next_control[`CTL_ENABLE_BIT])
            next_control[`CTL_GO_BIT] = 1'b0;
        // RULE8 clear go and flag
        if (end_of_conv)
        begin
            next_control[`CTL_GO_BIT] = 1'b0;
            next_irq_flag = 1'b1;
        end
        next_irq = next_irq_flag && next_irq_enable[`IRQ_CONV_BIT];
    end

    // Registers the configuration and drives the core controls.
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            control <= `CONTROL_RESET;
            clock_sel <= `CLOCK_SEL_RESET;
            pin_sel <= `PIN_SEL_RESET;
            irq_enable <= `IRQ_ENABLE_RESET;
            irq_flag <= 1'b0;
            IRQ <= 1'b0;
            CHANNEL <= `CHANNEL_RESET;
            VREF_SELECT <= 1'b0;
            CONV_POWER <= 1'b0;
            PIN_ANALOG <= `PIN_SEL_RESET;
        end
        else
        begin
            control <= next_control;
            clock_sel <= next_clock_sel;
            pin_sel <= next_pin_sel;
            irq_enable <= next_irq_enable;
            irq_flag <= next_irq_flag;
            IRQ <= next_irq;
            CHANNEL <= next_control[`CTL_CHAN_MSB:`CTL_CHAN_LSB];
            VREF_SELECT <= next_control[`CTL_VREF_BIT];
            CONV_POWER <= next_control[`CTL_ENABLE_BIT];
            PIN_ANALOG <= next_pin_sel;
        end
    end

    // Computes the result bytes; the finished conversion wins over
    // a software write, and nothing changes while reset is held.
    always_comb
    begin
        next_result_high = result_high;
        next_result_low = result_low;
        if (!RST_N)
        begin
            next_result_high = result_high;
            next_result_low = result_low;
        end
        // RULE8 store both bytes
        else if (end_of_conv)
        begin
            next_result_high = pack_high;
            next_result_low = pack_low;
        end
        else if (WR && ADDR == `OFS_RESULT_HIGH)
            next_result_high = WDATA;
        else if (WR && ADDR == `OFS_RESULT_LOW)
            next_result_low = WDATA;
    end

    // RULE7 result kept over reset
    always_ff @(posedge CLOCK)
    begin
        result_high <= next_result_high;
        result_low <= next_result_low;
    end

    // Selects the read data; unmapped offsets read as zero.
    always_comb
    begin
        next_rdata = `ZERO_BYTE;
        if (!RD)
            next_rdata = `ZERO_BYTE;
        else if (ADDR == `OFS_CONTROL)
            next_rdata = control;
        else if (ADDR == `OFS_CLOCK_SEL)
            next_rdata = clock_sel;
        else if (ADDR == `OFS_PIN_SEL)
            next_rdata = pin_sel;
        else if (ADDR == `OFS_RESULT_HIGH)
            next_rdata = result_high;
        else if (ADDR == `OFS_RESULT_LOW)
            next_rdata = result_low;
        else if (ADDR == `OFS_IRQ_ENABLE)
            next_rdata = irq_enable;
        else if (ADDR == `OFS_IRQ_FLAGS)
            next_rdata[`IRQ_CONV_BIT] = irq_flag;
    end

    // Registers the read data for the cycle after the strobe.
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            RDATA <= `ZERO_BYTE;
        else
            RDATA <= next_rdata;
    end

    // RULE1 left high check
    left_high_a: assert property (@(posedge CLOCK) // RULE1
        disable iff (!RST_N)
        end_of_conv && !format_bit |=>
        result_high == $past(sample_sync[9:2]))
    else $error("left high byte wrong");

    // RULE2 left low check
    left_low_a: assert property (@(posedge CLOCK) // RULE2
        disable iff (!RST_N)
        end_of_conv && !format_bit |=>
        result_low == {$past(sample_sync[1:0]), `RESULT_PAD})
    else $error("left low byte wrong");

    // RULE3 right high check
    right_high_a: assert property (@(posedge CLOCK) // RULE3
        disable iff (!RST_N)
        end_of_conv && format_bit |=>
        result_high == {`RESULT_PAD, $past(sample_sync[9:8])})
    else $error("right high byte wrong");

    // RULE4 right low check
    right_low_a: assert property (@(posedge CLOCK) // RULE4
        disable iff (!RST_N)
        end_of_conv && format_bit |=>
        result_low == $past(sample_sync[7:0]))
    else $error("right low byte wrong");

    // RULE5 full result check
    full_result_a: assert property (@(posedge CLOCK) // RULE5
        disable iff (!RST_N)
        end_of_conv |=>
        ($past(format_bit) ? {result_high[1:0], result_low}
        : {result_high, result_low[7:6]}) == $past(sample_sync))
    else $error("result bits lost");

    // RULE7 reset hold check
    reset_hold_a: assert property (@(posedge CLOCK) // RULE7
        !RST_N |=> $stable(result_high) && $stable(result_low))
    else $error("result changed in reset");

    // RULE8 end effects check
    conv_end_a: assert property (@(posedge CLOCK) // RULE8
        disable iff (!RST_N)
        end_of_conv |=> !go_bit && irq_flag && !SAMPLE_HOLD)
    else $error("conversion end effects missing");

    // Interrupt level follows the masked flag.
    irq_level_a: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        IRQ == (irq_flag && irq_enable[`IRQ_CONV_BIT]))
    else $error("interrupt level wrong");

endmodule

// *** hw/adc_fmt_regs.svh ***
// Operation
// RULE1 - Left format: result nine..two fill high byte.
// RULE2 - Left format: bits one..zero top low.
// RULE3 - Right format: bits nine..eight low high.
// RULE4 - Right format: bits seven..zero fill low.
// RULE5 - Ten bit result, both bytes carry all.
// RULE6 - Software waits acquisition time before starting.
// RULE7 - Result bytes untouched by any reset.
// RULE8 - Conversion end: store, clear go, flag.
`ifndef ADC_FMT_REGS_SVH
`define ADC_FMT_REGS_SVH

// Register offsets on the plain register port.
`define OFS_CONTROL 8'h00
`define OFS_CLOCK_SEL 8'h01
`define OFS_PIN_SEL 8'h02
`define OFS_RESULT_HIGH 8'h03
`define OFS_RESULT_LOW 8'h04
`define OFS_IRQ_ENABLE 8'h05
`define OFS_IRQ_FLAGS 8'h06

// Control register fields.
`define CTL_FORMAT_BIT 7
`define CTL_VREF_BIT 6
`define CTL_CHAN_MSB 4
`define CTL_CHAN_LSB 2
`define CTL_GO_BIT 1
`define CTL_ENABLE_BIT 0
`define CTL_WRITE_MASK 8'hDF
`define CLKSEL_WRITE_MASK 8'h70
`define CLKSEL_MSB 6
`define CLKSEL_LSB 4

// Converter event bit in both interrupt registers.
`define IRQ_CONV_BIT 6

// Reset values.
`define CONTROL_RESET 8'h00
`define CLOCK_SEL_RESET 8'h00
`define PIN_SEL_RESET 8'hFF
`define IRQ_ENABLE_RESET 8'h00
`define ZERO_BYTE 8'h00
`define SAMPLE_RESET 10'h000
`define CHANNEL_RESET 3'h0

// Result layout.
`define RESULT_WIDTH 10
`define RESULT_STEPS 1024
`define RESULT_PAD 6'h00

// Conversion clock select codes and divide ratios.
`define CLKSEL_FOSC2 3'h0
`define CLKSEL_FOSC8 3'h1
`define CLKSEL_FOSC32 3'h2
`define CLKSEL_FOSC4 3'h4
`define CLKSEL_FOSC16 3'h5
`define CLKSEL_FOSC64 3'h6
`define DIV_FOSC2 9'h002
`define DIV_FOSC8 9'h008
`define DIV_FOSC32 9'h020
`define DIV_FOSC4 9'h004
`define DIV_FOSC16 9'h010
`define DIV_FOSC64 9'h040
`define DIV_COUNT_ZERO 9'h000
`define DIV_COUNT_ONE 9'h001

// Timing: the system clock and internal conversion oscillator periods in nanoseconds.
`define CLOCK_PERIOD_NS 5
`define FRC_PERIOD_NS 2000
`define FRC_DIV_CYCLES \
    ((`FRC_PERIOD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// Conversion length in conversion clock periods.
`define CONV_TAD_COUNT 4'hB
`define TAD_ZERO 4'h0
`define TAD_ONE 4'h1

`endif

// *** hw/adc_fmt_pkg.sv ***
// Shared types of the result formatting block.
package adc_fmt_pkg;

    // Conversion sequencer states.
    typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;

endpackage

// *** hw/tad_divider.sv ***
`include "adc_fmt_regs.svh"

// Makes the conversion clock as a one-cycle enable pulse.
module tad_divider (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Control.
    input wire logic run,
    input wire logic [2:0] select,
    // Enable pulse out.
    output logic tick
);

    logic [8:0] count; // Cycles into the current period.
    logic [8:0] next_count; // Next cycle count.
    logic [8:0] period; // Selected period in system cycles.
    logic next_tick; // Next pulse value.

    // Picks the period and advances the count while running.
    always_comb
    begin
        case (select)
            `CLKSEL_FOSC2: period = `DIV_FOSC2;
            `CLKSEL_FOSC8: period = `DIV_FOSC8;
            `CLKSEL_FOSC32: period = `DIV_FOSC32;
            `CLKSEL_FOSC4: period = `DIV_FOSC4;
            `CLKSEL_FOSC16: period = `DIV_FOSC16;
            `CLKSEL_FOSC64: period = `DIV_FOSC64;
            // Both remaining codes select the internal oscillator rate.
            default: period = 9'(`FRC_DIV_CYCLES);
        endcase
        next_count = count + `DIV_COUNT_ONE;
        next_tick = 1'b0;
        if (!run)
            next_count = `DIV_COUNT_ZERO;
        else if (count == period - `DIV_COUNT_ONE)
        begin
            next_count = `DIV_COUNT_ZERO;
            next_tick = 1'b1;
        end
    end

    // Registers the count and the pulse.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            count <= `DIV_COUNT_ZERO;
            tick <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick <= next_tick;
        end
    end

endmodule

// *** hw/result_packer.sv ***
`include "adc_fmt_regs.svh"

// Splits a ten-bit result into the two result bytes.
module result_packer (
    // Result and format.
    input wire logic [9:0] value,
    input wire logic right_justify,
    // Byte images.
    output logic [7:0] high_byte,
    output logic [7:0] low_byte
);

    // Reserved bits are filled with zero in either layout.
    // RULE5 all ten bits
    always_comb
    begin
        if (right_justify)
        begin
            // RULE3 right high byte
            high_byte = {`RESULT_PAD, value[9:8]};
            // RULE4 right low byte
            low_byte = value[7:0];
        end
        else
        begin
            // RULE1 left high byte
            high_byte = value[9:2];
            // RULE2 left low byte
            low_byte = {value[1:0], `RESULT_PAD};
        end
    end

endmodule

// *** test/analog_channel_model.sv ***
// Behavioural model of the analog pins seen through the hold capacitor.
module analog_channel_model (
    // Clock.
    input wire logic clock,
    // Level programming from the bench.
    input wire logic set_en,
    input wire logic [2:0] set_chan,
    input wire logic [9:0] set_level,
    // Converter side.
    input wire logic [2:0] channel,
    input wire logic powered,
    output logic [9:0] sample
);
    timeunit 1ns;
    timeprecision 1ps;

    // Settled level of each of the eight input pins.
    logic [9:0] level [8];
    // Pattern that flips every cycle while the converter is off.
    logic [9:0] churn = 10'h000;

    // Stores new pin levels and toggles the idle pattern.
    always_ff @(posedge clock)
    begin
        churn <= ~churn;
        if (set_en)
        begin
            level[set_chan] <= set_level;
        end
    end

    // ten bit level
    // A powered converter sees the selected pin; otherwise nothing stable.
    assign sample = powered ? level[channel] : churn;
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the result formatting registers.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset and register port.
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    // Converter side and interrupt.
    logic [9:0] sample;
    logic [2:0] channel;
    logic vref;
    logic power;
    logic hold;
    logic [7:0] pins;
    logic irq;
    // Level programming of the channel model.
    logic set_en = 1'b0;
    logic [2:0] set_chan = 3'h0;
    logic [9:0] set_level = 10'h000;
    // Counters and the last expected result bytes.
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] exp_hi;
    logic [7:0] exp_lo;
    // Pin levels used by the conversion sweep, boundaries first.
    logic [9:0] vals [8] = '{10'h3FF, 10'h000, 10'h2AA, 10'h155,
                             10'h201, 10'h1FE, 10'h3C3, 10'h03C};

    // The clock toggles every half period of 5 ns.
    always #2.5 clock = ~clock;

    // Cuts a hung run short after a generous number of cycles.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles >= 40000)
        begin
            bad_count++;
            $display("ERROR at %0t: run timed out", $time);
            results();
        end
    end

    adc_result_format_regs dut_u (
        .CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .CONV_SAMPLE(sample),
        .CHANNEL(channel), .VREF_SELECT(vref), .CONV_POWER(power),
        .SAMPLE_HOLD(hold), .PIN_ANALOG(pins), .IRQ(irq)
    );

    analog_channel_model chan_u (
        .clock(clock), .set_en(set_en), .set_chan(set_chan),
        .set_level(set_level), .channel(channel), .powered(power),
        .sample(sample)
    );

    // Compares one value and reports a difference at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle register write.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // One-cycle register read; data are taken in the following cycle.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Reads a register and compares it.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd_reg(a, v);
        check(v, exp);
    endtask

    // Expected high and low bytes for a result in the chosen format.
    function automatic logic [15:0] pack(input logic fmt,
                                         input logic [9:0] r);
        return fmt ? {6'h00, r[9:8], r[7:0]} : {r[9:2], r[1:0], 6'h00};
    endfunction

    // Runs one conversion and checks bytes, go, flag and interrupt.
    task automatic convert(input logic fmt, input logic [2:0] code,
                           input logic [2:0] ch, input logic [9:0] r);
        int k;
        logic [7:0] v;
        logic [7:0] ctl;
        ctl = {fmt, code[1], 1'b0, ch, 2'b01};
        @(posedge clock);
        set_en <= 1'b1;
        set_chan <= ch;
        set_level <= r;
        @(posedge clock);
        set_en <= 1'b0;
        wr_reg(8'h01, {1'b0, code, 4'h0});
        wr_reg(8'h00, ctl);
        repeat (20) @(posedge clock);
        wr_reg(8'h00, ctl | 8'h02);
        // The hold output rises one cycle after go is stored.
        @(posedge clock);
        #1;
        check({7'h00, hold}, 8'h01);
        k = 0;
        v = 8'h02;
        // Polls until hardware drops the go bit.
        while (v[1] !== 1'b0 && k < 3000)
        begin
            rd_reg(8'h00, v);
            k++;
        end
        {exp_hi, exp_lo} = pack(fmt, r);
        check(v, ctl);
        check({3'h0, vref, power, channel}, {3'h0, code[1], 1'b1, ch});
        rd_chk(8'h03, exp_hi);
        check({6'h00, irq, hold}, 8'h02);
        rd_chk(8'h04, exp_lo);
        rd_chk(8'h06, 8'h40);
        rd_chk(8'h06, 8'h00);
        check({7'h00, irq}, 8'h00);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence of tests.
    initial
    begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values of the configuration registers and a hole.
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h02, 8'hFF);
        rd_chk(8'h05, 8'h00);
        rd_chk(8'h06, 8'h00);
        rd_chk(8'h07, 8'h00);
        check(pins, 8'hFF);
        $display("test reset values done");
        wr_reg(8'h05, 8'h40);
        // Every clock code, both formats, every channel.
        for (int i = 0; i < 8; i++)
        begin
            convert(i[0], i[2:0], i[2:0], vals[i]);
        end
        $display("test conversions done");
        // A second reset must leave the result bytes alone.
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(8'h03, exp_hi);
        rd_chk(8'h04, exp_lo);
        rd_chk(8'h00, 8'h00);
        $display("test reset keeps result done");
        // Dropping enable mid-run stores nothing and sets no flag.
        wr_reg(8'h05, 8'h40);
        wr_reg(8'h01, 8'h60);
        wr_reg(8'h00, 8'h01);
        repeat (20) @(posedge clock);
        wr_reg(8'h00, 8'h03);
        repeat (10) @(posedge clock);
        wr_reg(8'h00, 8'h00);
        repeat (1000) @(posedge clock);
        rd_chk(8'h06, 8'h00);
        rd_chk(8'h03, exp_hi);
        check({7'h00, irq}, 8'h00);
        $display("test abort done");
        // The high result byte is writable; the flag is writable and masked.
        wr_reg(8'h03, 8'hA5);
        rd_chk(8'h03, 8'hA5);
        wr_reg(8'h06, 8'h40);
        rd_chk(8'h05, 8'h40);
        check({7'h00, irq}, 8'h01);
        wr_reg(8'h05, 8'h00);
        rd_chk(8'h05, 8'h00);
        check({7'h00, irq}, 8'h00);
        rd_chk(8'h06, 8'h40);
        rd_chk(8'h06, 8'h00);
        // Low byte, pin select, masked fields and a dropped go.
        wr_reg(8'h04, 8'h3C);
        rd_chk(8'h04, 8'h3C);
        wr_reg(8'h02, 8'h5A);
        rd_chk(8'h02, 8'h5A);
        check(pins, 8'h5A);
        wr_reg(8'h01, 8'hFF);
        rd_chk(8'h01, 8'h70);
        wr_reg(8'h00, 8'h02);
        rd_chk(8'h00, 8'h00);
        wr_reg(8'h00, 8'hFC);
        rd_chk(8'h00, 8'hDC);
        check({3'h0, vref, power, channel}, 8'h17);
        $display("test register access done");
        results();
    end
endmodule
